// file: rtl/cda_regs.svh
// Register offsets, field positions, reset values and timing counts of the acquisition block.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data words.
`ifndef CDA_REGS_SVH
`define CDA_REGS_SVH
`define CDA_ADDR_W 8
`define CDA_CTRL_OFS 8'h00
`define CDA_CMD_OFS 8'h04
`define CDA_MASK_OFS 8'h08
`define CDA_PATTERN_OFS 8'h0C
`define CDA_PRETRIG_OFS 8'h10
`define CDA_POSTTRIG_OFS 8'h14
`define CDA_STATUS_OFS 8'h18
`define CDA_IRQ_MASK_OFS 8'h1C
`define CDA_DATA_OFS 8'h20
`define CDA_FILL_OFS 8'h24
`define CDA_IN_CNT_LO_OFS 8'h28
`define CDA_IN_CNT_HI_OFS 8'h2C
`define CDA_OUT_CNT_LO_OFS 8'h30
`define CDA_OUT_CNT_HI_OFS 8'h34
`define CDA_OUT_DATA_OFS 8'h38
`define CDA_CTRL_TRIG_LSB 0
`define CDA_CTRL_WIDTH_LSB 2
`define CDA_CTRL_GRP_BIT 4
`define CDA_CTRL_IRQX_BIT 5
`define CDA_CTRL_PRELOAD_DIS_BIT 6
`define CDA_CTRL_PAT_EN_BIT 7
`define CDA_CTRL_PAT_POL_BIT 8
`define CDA_CMD_START_BIT 0
`define CDA_CMD_ABORT_BIT 1
`define CDA_CMD_OUT_START_BIT 2
`define CDA_ST_SAMPLE_BIT 0
`define CDA_ST_BLOCK_BIT 1
`define CDA_ST_PREERR_BIT 2
`define CDA_ST_DONE_BIT 3
`define CDA_ST_OVF_BIT 4
`define CDA_ST_W 5
`define CDA_CTRL_RST 32'h0000_0000
`define CDA_MASK_RST 32'hFFFF_FFFF
`define CDA_CLK_NS 20
`define CDA_CAP_MIN_NS 50
`define CDA_CAP_MAX_NS 150
`define CDA_CAP_MIN_CYC ((`CDA_CAP_MIN_NS + `CDA_CLK_NS - 1) / `CDA_CLK_NS)
`define CDA_CAP_MAX_CYC (`CDA_CAP_MAX_NS / `CDA_CLK_NS)
`define CDA_RESP_OKAY 2'h0
`define CDA_RESP_SLVERR 2'h2
`endif

// file: rtl/cda_pkg.sv
// Types shared by the acquisition block modules.
// Assumes nothing of its surroundings.
package cda_pkg;
  typedef enum logic [1:0] {CDA_W8, CDA_W16, CDA_W32, CDA_WRSV} cda_width_t;
  typedef enum logic [1:0] {CDA_TRIG_NONE, CDA_TRIG_START, CDA_TRIG_STOP, CDA_TRIG_BOTH} cda_trig_t;
endpackage : cda_pkg

// file: rtl/cda_cap_if.sv
// Carrier between the line detector and the block core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cda_cap_if;
  logic [31:0] mask;
  logic [31:0] pattern;
  logic [1:0] width;
  logic grp;
  logic pat_pol;
  logic [31:0] sample;
  logic change;
  logic pat_hit;
  logic start_rise;
  logic stop_rise;
  modport det (input mask, pattern, width, grp, pat_pol, output sample, change, pat_hit, start_rise, stop_rise);
  modport core (output mask, pattern, width, grp, pat_pol, input sample, change, pat_hit, start_rise, stop_rise);
endinterface : cda_cap_if
`default_nettype wire

// file: rtl/cda_change_det.sv
// Input line synchroniser, port selection and masked change detection.
// Assumes pins are asynchronous to i_ref_clk; all outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module cda_change_det
  import cda_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [31:0] i_lines,
  input wire logic i_start_trigger_in,
  input wire logic i_stop_trigger_in,
  cda_cap_if.det cap
);
  logic [33:0] s1_q, s2_q, s3_q, st_q, st_d;
  logic [31:0] sel_now, sel_new, msk;

  // Selected port lines, right aligned; unused upper bits read zero
  function automatic logic [31:0] port_sel(input logic [31:0] l, input logic [1:0] w, input logic g);
    case (w)
      CDA_W16: port_sel = g ? {16'h0000, l[31:16]} : {16'h0000, l[15:0]};
      CDA_W32: port_sel = l;
      default: port_sel = g ? {24'h000000, l[23:16]} : {24'h000000, l[7:0]};
    endcase
  endfunction : port_sel

  // A bit moves only once the second and third stages agree
  assign st_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
  assign sel_now = port_sel(st_q[31:0], cap.width, cap.grp);
  assign sel_new = port_sel(st_d[31:0], cap.width, cap.grp);
  assign msk = cap.mask & port_sel(32'hFFFF_FFFF, cap.width, cap.grp);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      s1_q <= 34'h0;
      s2_q <= 34'h0;
      s3_q <= 34'h0;
      st_q <= 34'h0;
    end else begin
      s1_q <= {i_stop_trigger_in, i_start_trigger_in, i_lines};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cap.sample <= 32'h0;
      cap.change <= 1'b0;
      cap.pat_hit <= 1'b0;
      cap.start_rise <= 1'b0;
      cap.stop_rise <= 1'b0;
    end else begin
      cap.sample <= sel_new;
      cap.change <= |((sel_new ^ sel_now) & msk);
      cap.pat_hit <= (((sel_new ^ cap.pattern) & msk) == 32'h0) ^ cap.pat_pol;
      cap.start_rise <= st_d[32] & ~st_q[32];
      cap.stop_rise <= st_d[33] & ~st_q[33];
    end
  end
endmodule : cda_change_det
`default_nettype wire

// file: rtl/cda_out_buf.sv
// Onboard output memory with optional preload before output begins.
// Assumes pushes come from register writes; emits one word per clock while running.
`timescale 1ns/1ps
`default_nettype none
module cda_out_buf #(
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_push,
  input wire logic [31:0] i_data,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_preload_en,
  output logic [31:0] o_lines,
  output logic o_valid,
  output logic o_full
);
  localparam int AW = $clog2(DEPTH);
  logic [31:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic run_q, wait_q, pop, push;

  assign o_full = (cnt_q == (AW+1)'(DEPTH));
  assign push = i_push & ~o_full;
  assign pop = run_q & ~wait_q & (cnt_q != '0);

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // hold output until memory is full
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_abort) begin
      run_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (i_start) begin
      run_q <= 1'b1;
      wait_q <= i_preload_en;
    end else if (wait_q && o_full) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_lines <= 32'h0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= pop;
      if (pop) begin
        o_lines <= mem[rp_q];
      end
    end
  end
endmodule : cda_out_buf
`default_nettype wire

// file: rtl/cda_top.sv
// Change-detection acquisition block with AXI4-Lite registers and one interrupt.
// Assumes data and trigger pins are asynchronous; host polls or takes the interrupt.
// Operation
// - monitored change captures data, pulses strobe
// - only masked lines count as changes
// - whole configured port is latched
// - width selectable as 8, 16, 32
// - fixed port and group combinations
// - no trigger starts on software command
// - start mode waits for start trigger
// - stop trigger keeps pre, captures post
// - early stop trigger flags an error
// - block event marks each whole block, remainder stays
// - interrupt mode offers every sample immediately
// - output preloads memory unless disabled
// - pattern trigger uses change mask
`timescale 1ns/1ps
`default_nettype none
`include "cda_regs.svh"
module cda_top
  import cda_pkg::*;
#(
  parameter int BLOCK_BYTES = 32,
  parameter int OUT_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [`CDA_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [`CDA_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_port_zero_lines,
  input wire logic [7:0] i_port_one_lines,
  input wire logic [7:0] i_port_two_lines,
  input wire logic [7:0] i_port_three_lines,
  input wire logic i_start_trigger_in,
  input wire logic i_stop_trigger_in,
  output logic o_sample_strobe,
  output logic [31:0] o_out_lines,
  output logic o_out_valid,
  output logic o_busy,
  output logic o_irq
);
  localparam int BW = $clog2(BLOCK_BYTES + 1);
  localparam int AW = $clog2(BLOCK_BYTES);
  typedef enum logic [2:0] {CDA_IDLE, CDA_WAIT_START, CDA_RUN, CDA_POST} cda_state_t;

  cda_cap_if cap ();
  cda_state_t state_q;
  logic [31:0] ctrl_q, mask_q, pattern_q, pre_q, post_q, pre_cnt_q, post_cnt_q, rdata, snap_hi_q;
  logic [`CDA_ST_W-1:0] status_q, irq_mask_q, ev;
  logic [63:0] in_cnt_q [2];
  logic [63:0] out_cnt_q [2];
  logic [31:0] mem [BLOCK_BYTES];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] ent_q;
  logic [BW-1:0] fill_q, fill_d, bps;
  logic [`CDA_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic aw_have_q, w_have_q, wr_go, rd_go, cmd_start, cmd_abort, cmd_out, out_push;
  logic acq, push, pop, full, rd_status, rd_data, rd_lo, rd_olo, rd_hit, wr_hit;
  logic start_ev, stop_ev;
  cda_trig_t trig;

  assign trig = cda_trig_t'(ctrl_q[`CDA_CTRL_TRIG_LSB +: 2]);
  assign cap.mask = mask_q;
  assign cap.pattern = pattern_q;
  assign cap.width = ctrl_q[`CDA_CTRL_WIDTH_LSB +: 2];
  assign cap.grp = (cap.width == CDA_W32) ? 1'b0 : ctrl_q[`CDA_CTRL_GRP_BIT];
  assign cap.pat_pol = ctrl_q[`CDA_CTRL_PAT_POL_BIT];

  cda_change_det u_det (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_lines({i_port_three_lines, i_port_two_lines, i_port_one_lines, i_port_zero_lines}),
    .i_start_trigger_in(i_start_trigger_in),
    .i_stop_trigger_in(i_stop_trigger_in),
    .cap(cap)
  );

  // Write channel: address and data taken in either order
  assign o_s_axi_awready = ~aw_have_q;
  assign o_s_axi_wready = ~w_have_q;
  assign wr_go = aw_have_q & w_have_q & ~o_s_axi_bvalid;
  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign rd_go = i_s_axi_arvalid & o_s_axi_arready;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `CDA_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? `CDA_RESP_OKAY : `CDA_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte strobes are ignored: every register is written as a whole word
  always_comb begin
    wr_hit = 1'b1;
    case (awaddr_q)
      `CDA_CTRL_OFS, `CDA_CMD_OFS, `CDA_MASK_OFS, `CDA_PATTERN_OFS, `CDA_PRETRIG_OFS,
      `CDA_POSTTRIG_OFS, `CDA_IRQ_MASK_OFS, `CDA_OUT_DATA_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign cmd_start = wr_go & (awaddr_q == `CDA_CMD_OFS) & wdata_q[`CDA_CMD_START_BIT];
  assign cmd_abort = wr_go & (awaddr_q == `CDA_CMD_OFS) & wdata_q[`CDA_CMD_ABORT_BIT];
  assign cmd_out = wr_go & (awaddr_q == `CDA_CMD_OFS) & wdata_q[`CDA_CMD_OUT_START_BIT];
  assign out_push = wr_go & (awaddr_q == `CDA_OUT_DATA_OFS);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= `CDA_CTRL_RST;
      mask_q <= `CDA_MASK_RST;
      pattern_q <= 32'h0;
      pre_q <= 32'h0;
      post_q <= 32'h0;
      irq_mask_q <= '0;
    end else if (wr_go) begin
      case (awaddr_q)
        `CDA_CTRL_OFS: ctrl_q <= wdata_q;
        `CDA_MASK_OFS: mask_q <= wdata_q;
        `CDA_PATTERN_OFS: pattern_q <= wdata_q;
        `CDA_PRETRIG_OFS: pre_q <= wdata_q;
        `CDA_POSTTRIG_OFS: post_q <= wdata_q;
        `CDA_IRQ_MASK_OFS: irq_mask_q <= wdata_q[`CDA_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Trigger sources: pin edges, or a pattern hit when enabled
  assign start_ev = cap.start_rise | (ctrl_q[`CDA_CTRL_PAT_EN_BIT] & cap.pat_hit);
  assign stop_ev = cap.stop_rise | (ctrl_q[`CDA_CTRL_PAT_EN_BIT] & cap.pat_hit);
  assign acq = (state_q == CDA_RUN) | (state_q == CDA_POST);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || cmd_abort) begin
      state_q <= CDA_IDLE;
      pre_cnt_q <= 32'h0;
      post_cnt_q <= 32'h0;
    end else begin
      case (state_q)
        CDA_IDLE: begin
          if (cmd_start) begin
            pre_cnt_q <= 32'h0;
            post_cnt_q <= 32'h0;
            state_q <= (trig == CDA_TRIG_START || trig == CDA_TRIG_BOTH) ? CDA_WAIT_START : CDA_RUN;
          end
        end
        CDA_WAIT_START: begin
          if (start_ev) begin
            state_q <= CDA_RUN;
          end
        end
        CDA_RUN: begin
          if (push && pre_cnt_q != 32'hFFFF_FFFF) begin
            pre_cnt_q <= pre_cnt_q + 32'h1;
          end
          if ((trig == CDA_TRIG_STOP || trig == CDA_TRIG_BOTH) && stop_ev) begin
            state_q <= (post_q == 32'h0) ? CDA_IDLE : CDA_POST;
          end
        end
        CDA_POST: begin
          if (push) begin
            post_cnt_q <= post_cnt_q + 32'h1;
            if (post_cnt_q + 32'h1 >= post_q) begin
              state_q <= CDA_IDLE;
            end
          end
        end
        default: state_q <= CDA_IDLE;
      endcase
    end
  end

  // strobe and capture on a monitored change
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_sample_strobe <= 1'b0;
    end else begin
      o_sample_strobe <= cap.change & acq;
    end
  end

  // block buffer; sub-block remainder is kept
  assign bps = (cap.width == CDA_W32) ? BW'(4) : (cap.width == CDA_W16) ? BW'(2) : BW'(1);
  assign full = (ent_q == (AW+1)'(BLOCK_BYTES)) | (fill_q + bps > BW'(BLOCK_BYTES));
  assign push = cap.change & acq & ~full;
  assign rd_data = rd_go & (i_s_axi_araddr == `CDA_DATA_OFS);
  assign pop = rd_data & (ent_q != '0);
  assign fill_d = fill_q + (push ? bps : BW'(0)) - (pop ? bps : BW'(0));

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp_q] <= cap.sample;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || cmd_start) begin
      wp_q <= '0;
      rp_q <= '0;
      ent_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(BLOCK_BYTES-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(BLOCK_BYTES-1)) ? '0 : rp_q + 1'b1;
      end
      ent_q <= ent_q + (AW+1)'(push) - (AW+1)'(pop);
      fill_q <= fill_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      in_cnt_q[0] <= 64'h0;
      in_cnt_q[1] <= 64'h0;
      out_cnt_q[0] <= 64'h0;
      out_cnt_q[1] <= 64'h0;
    end else begin
      if (cmd_start) begin
        in_cnt_q[cap.grp] <= 64'h0;
      end else if (push) begin
        in_cnt_q[cap.grp] <= in_cnt_q[cap.grp] + 64'h1;
      end
      if (cmd_out) begin
        out_cnt_q[cap.grp] <= 64'h0;
      end else if (o_out_valid) begin
        out_cnt_q[cap.grp] <= out_cnt_q[cap.grp] + 64'h1;
      end
    end
  end

  // Sticky events; a set in the clearing read cycle survives
  always_comb begin
    ev = '0;
    ev[`CDA_ST_SAMPLE_BIT] = push & ctrl_q[`CDA_CTRL_IRQX_BIT];
    ev[`CDA_ST_BLOCK_BIT] = ~ctrl_q[`CDA_CTRL_IRQX_BIT] & (fill_d >= BW'(BLOCK_BYTES))
      & (fill_q < BW'(BLOCK_BYTES));
    ev[`CDA_ST_PREERR_BIT] = (state_q == CDA_RUN) & (trig == CDA_TRIG_STOP || trig == CDA_TRIG_BOTH)
      & stop_ev & (pre_cnt_q < pre_q);
    ev[`CDA_ST_DONE_BIT] = acq & ~cmd_abort & (((state_q == CDA_POST) & push & (post_cnt_q + 32'h1 >= post_q))
      | ((state_q == CDA_RUN) & (trig == CDA_TRIG_STOP || trig == CDA_TRIG_BOTH) & stop_ev & (post_q == 32'h0)));
    ev[`CDA_ST_OVF_BIT] = cap.change & acq & full;
  end

  assign rd_status = rd_go & (i_s_axi_araddr == `CDA_STATUS_OFS);
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | ev;
    end
  end
  assign o_irq = |(status_q & irq_mask_q);
  assign o_busy = state_q != CDA_IDLE;

  // low-half read freezes the high half
  assign rd_lo = rd_go & (i_s_axi_araddr == `CDA_IN_CNT_LO_OFS);
  assign rd_olo = rd_go & (i_s_axi_araddr == `CDA_OUT_CNT_LO_OFS);
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      snap_hi_q <= 32'h0;
    end else if (rd_lo) begin
      snap_hi_q <= in_cnt_q[cap.grp][63:32];
    end else if (rd_olo) begin
      snap_hi_q <= out_cnt_q[cap.grp][63:32];
    end
  end

  always_comb begin
    rdata = 32'h0;
    rd_hit = 1'b1;
    case (i_s_axi_araddr)
      `CDA_CTRL_OFS: rdata = ctrl_q;
      `CDA_MASK_OFS: rdata = mask_q;
      `CDA_PATTERN_OFS: rdata = pattern_q;
      `CDA_PRETRIG_OFS: rdata = pre_q;
      `CDA_POSTTRIG_OFS: rdata = post_q;
      `CDA_STATUS_OFS: rdata = 32'(status_q);
      `CDA_IRQ_MASK_OFS: rdata = 32'(irq_mask_q);
      `CDA_DATA_OFS: rdata = (ent_q != '0) ? mem[rp_q] : 32'h0;
      `CDA_FILL_OFS: rdata = {13'h0000, 3'(state_q), 8'(ent_q), 8'(fill_q)};
      `CDA_IN_CNT_LO_OFS: rdata = in_cnt_q[cap.grp][31:0];
      `CDA_IN_CNT_HI_OFS, `CDA_OUT_CNT_HI_OFS: rdata = snap_hi_q;
      `CDA_OUT_CNT_LO_OFS: rdata = out_cnt_q[cap.grp][31:0];
      `CDA_CMD_OFS, `CDA_OUT_DATA_OFS: rdata = 32'h0;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= `CDA_RESP_OKAY;
    end else if (rd_go) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rdata;
      o_s_axi_rresp <= rd_hit ? `CDA_RESP_OKAY : `CDA_RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  cda_out_buf #(.DEPTH(OUT_DEPTH)) u_out (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_push(out_push),
    .i_data(wdata_q),
    .i_start(cmd_out),
    .i_abort(cmd_abort),
    .i_preload_en(~ctrl_q[`CDA_CTRL_PRELOAD_DIS_BIT]),
    .o_lines(o_out_lines),
    .o_valid(o_out_valid),
    .o_full()
  );
endmodule : cda_top
`default_nettype wire

// file: bench/cda_top_assertions.sv
// Port-level checks of the acquisition block.
// Assumes binding to cda_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cda_top_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_port_zero_lines,
  input wire logic [7:0] i_port_one_lines,
  input wire logic [7:0] i_port_two_lines,
  input wire logic [7:0] i_port_three_lines,
  input wire logic o_sample_strobe,
  input wire logic o_busy,
  input wire logic o_irq
);
  logic [31:0] lines;
  assign lines = {i_port_three_lines, i_port_two_lines, i_port_one_lines, i_port_zero_lines};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  strobe_pulse_a: assert property (o_sample_strobe |=> !o_sample_strobe)
    else $error("long strobe");
  // Change 3 to 7 cycles back
  strobe_latency_a: assert property (o_sample_strobe |-> $past(lines, 3) != $past(lines, 4)
    || $past(lines, 4) != $past(lines, 5) || $past(lines, 5) != $past(lines, 6) || $past(lines, 6) != $past(lines, 7))
    else $error("strobe without change");
  strobe_active_a: assert property (o_sample_strobe |-> $past(o_busy))
    else $error("strobe while idle");
  write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##[1:2] o_s_axi_bvalid) else $error("bvalid late");
  write_close_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("bvalid stuck");
  read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("rvalid late");
  read_gate_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while busy");
  read_close_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("rvalid stuck");
  reset_quiet_a: assert property ($rose(i_reset_n) |-> !o_irq && !o_busy)
    else $error("active after reset");
endmodule : cda_top_checker
bind cda_top cda_top_checker chk_i (.*);
`default_nettype wire

// file: bench/cda_periph.sv
// Behavioural peripheral driving data lines and trigger pins.
// Assumes requests change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module cda_periph (
  input wire logic i_ref_clk,
  input wire logic [31:0] i_word,
  input wire logic i_start_req,
  input wire logic i_stop_req,
  output logic [31:0] o_lines,
  output logic o_start_trig,
  output logic o_stop_trig
);
  logic [2:0] st_q = 3'h0, sp_q = 3'h0;
  always_ff @(posedge i_ref_clk) o_lines <= i_word;
  // Held four cycles: one clean edge
  always_ff @(posedge i_ref_clk) begin
    st_q <= i_start_req ? 3'h4 : st_q - 3'(st_q != 3'h0);
    sp_q <= i_stop_req ? 3'h4 : sp_q - 3'(sp_q != 3'h0);
  end
  assign o_start_trig = (st_q != 3'h0);
  assign o_stop_trig = (sp_q != 3'h0);
endmodule : cda_periph
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the acquisition block.
// Assumes the design, partner and checker compile with it.
`timescale 1ns/1ps
`default_nettype none
`include "cda_regs.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, st_req = 1'b0, sp_req = 1'b0;
  logic [31:0] wdata = 32'h0, word = 32'h0, rd, v, last_out;
  logic [1:0] rsp, w;
  logic g;
  wire logic awready, wready, bvalid, arready, rvalid, strobe, busy, irq, out_valid, t0, t1;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, out_lines, lines;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_strobe = 0, n_out = 0, s;
  always #10 clk = ~clk;
  cda_periph per (.i_ref_clk(clk), .i_word(word), .i_start_req(st_req), .i_stop_req(sp_req), .o_lines(lines),
    .o_start_trig(t0), .o_stop_trig(t1));
  cda_top #(.OUT_DEPTH(4)) dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_port_zero_lines(lines[7:0]), .i_port_one_lines(lines[15:8]), .i_port_two_lines(lines[23:16]),
    .i_port_three_lines(lines[31:24]), .i_start_trigger_in(t0), .i_stop_trigger_in(t1), .o_sample_strobe(strobe),
    .o_out_lines(out_lines), .o_out_valid(out_valid), .o_busy(busy), .o_irq(irq));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Ceiling far above test length
  always @(posedge clk) begin
    cyc++;
    if (strobe === 1'b1) n_strobe++;
    if (out_valid === 1'b1) begin
      n_out++;
      last_out = out_lines;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1'b0, dw = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw && dw)) begin
      @(negedge clk);
      aw |= awready;
      dw |= wready;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(negedge clk);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    rd = rdata; rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rdr
  task automatic put(input logic [31:0] nv);
    @(posedge clk);
    word <= nv;
    repeat (10) @(posedge clk);
  endtask : put
  task automatic pulse(input logic stop);
    @(posedge clk);
    if (stop) sp_req <= 1'b1; else st_req <= 1'b1;
    @(posedge clk);
    sp_req <= 1'b0; st_req <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse
  function automatic logic [31:0] exp_smp(input logic [31:0] x, input logic [1:0] wd, input logic gr);
    return (wd == 2'h2) ? x : (x >> (gr ? 16 : 0)) & ((wd == 2'h1) ? 32'hFFFF : 32'hFF);
  endfunction : exp_smp
  initial begin
    v = $urandom(15);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdr(`CDA_CTRL_OFS); chk("ctrl", `CDA_CTRL_RST, rd);
    rdr(`CDA_MASK_OFS); chk("mask", `CDA_MASK_RST, rd);
    rdr(8'h40); chk("rresp", 32'h2, {30'h0, rsp});
    wr(8'h40, 32'h1); chk("bresp", 32'h2, {30'h0, rsp});
    $display("reset test over");
    for (int c = 0; c < 5; c++) begin
      w = 2'(c / 2);
      g = c[0];
      wr(`CDA_CTRL_OFS, {27'h0, g, w, 2'h0});
      wr(`CDA_CMD_OFS, 32'h1);
      for (int k = 0; k < 3; k++) begin
        v = $urandom;
        v[g * 16] = ~word[g * 16];
        put(v);
        rdr(`CDA_DATA_OFS); chk("sample", exp_smp(v, w, g), rd);
      end
      rdr(`CDA_IN_CNT_LO_OFS); chk("count lo", 32'h3, rd);
      rdr(`CDA_IN_CNT_HI_OFS); chk("count hi", 32'h0, rd);
      wr(`CDA_CMD_OFS, 32'h2);
    end
    $display("width test over");
    wr(`CDA_CTRL_OFS, 32'h0); wr(`CDA_MASK_OFS, 32'h1); wr(`CDA_CMD_OFS, 32'h1);
    s = n_strobe;
    put(word ^ 32'hFFFF_FFFE); chk("unmasked strobe", s, n_strobe);
    put(word ^ 32'h1); chk("masked strobe", s + 1, n_strobe);
    rdr(`CDA_FILL_OFS); chk("fill", 32'h0002_0101, rd);
    rdr(`CDA_DATA_OFS); chk("whole port", exp_smp(word, 2'h0, 1'b0), rd);
    wr(`CDA_CMD_OFS, 32'h2); wr(`CDA_MASK_OFS, 32'hFFFF_FFFF);
    $display("mask test over");
    wr(`CDA_CTRL_OFS, 32'h1); wr(`CDA_CMD_OFS, 32'h1);
    put(word ^ 32'h1); rdr(`CDA_FILL_OFS); chk("waiting", 32'h0001_0000, rd);
    pulse(1'b0);
    put(word ^ 32'h1); rdr(`CDA_FILL_OFS); chk("started", 32'h0002_0101, rd);
    wr(`CDA_CMD_OFS, 32'h2);
    $display("start test over");
    wr(`CDA_PRETRIG_OFS, 32'h3); wr(`CDA_POSTTRIG_OFS, 32'h1); wr(`CDA_IRQ_MASK_OFS, 32'h4);
    wr(`CDA_CTRL_OFS, 32'h2); wr(`CDA_CMD_OFS, 32'h1);
    put(word ^ 32'h1); pulse(1'b1);
    chk("error irq", 32'h1, {31'h0, irq});
    put(word ^ 32'h1); rdr(`CDA_FILL_OFS); chk("stopped", 32'h0000_0202, rd);
    rdr(`CDA_STATUS_OFS); chk("error bit", 32'h4, rd & 32'h4);
    rdr(`CDA_STATUS_OFS); chk("cleared", 32'h0, rd);
    chk("irq low", 32'h0, {31'h0, irq});
    $display("stop test over");
    wr(`CDA_IRQ_MASK_OFS, 32'h1); wr(`CDA_CTRL_OFS, 32'h20); wr(`CDA_CMD_OFS, 32'h1);
    put(word ^ 32'h1); chk("sample irq", 32'h1, {31'h0, irq});
    rdr(`CDA_STATUS_OFS); chk("sample bit", 32'h1, rd & 32'h1);
    wr(`CDA_CMD_OFS, 32'h2);
    $display("irq test over");
    wr(`CDA_CTRL_OFS, 32'h0); wr(`CDA_OUT_DATA_OFS, $urandom); wr(`CDA_CMD_OFS, 32'h4);
    repeat (10) @(posedge clk);
    chk("preload hold", 32'h0, n_out);
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      wr(`CDA_OUT_DATA_OFS, v);
    end
    repeat (10) @(posedge clk);
    chk("preload run", 32'h4, n_out);
    chk("last out", v, last_out);
    v = $urandom;
    wr(`CDA_CTRL_OFS, 32'h40); wr(`CDA_OUT_DATA_OFS, v); wr(`CDA_CMD_OFS, 32'h4);
    repeat (10) @(posedge clk);
    chk("no preload", v, last_out);
    $display("output test over");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
